//--- verilog/uart_transmit_multiproc.sv
// serial transmitter with nine-bit multidrop mode, behind a wishbone slave
//
// How it works
// - holding-empty flag reads 1 when a byte can be taken, 0 while full.
// - a written byte moves to the shifter on its own and is sent.
// - ninth bit equals the address marker: 1 address byte, 0 data byte.
// - address marker acts only while nine-bit mode is on.
// - control one bit 6 enables nine-bit mode; resets to 0, eight-bit framing.
// - control one bit 3 sets driver-enable polarity: 0 high, 1 low.
// - with flow gate enabled, clear-to-send pin gates sending; otherwise ignored.
// - transmit-ready output says the holding register can take a byte.
// - transmit-on bit in control zero enables sending; clear means no new frame starts.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps

module uart_transmit_multiproc (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [uart_tx_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [uart_tx_pkg::SEL_W-1:0] wb_sel_i,
    input  wire logic [uart_tx_pkg::DAT_W-1:0] wb_dat_i,
    output logic      [uart_tx_pkg::DAT_W-1:0] wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic                          cts_n_i,
    output logic                               txd_o,
    output logic                               line_driver_on_o,
    output logic                               tx_holding_empty_o
);
    import uart_tx_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                ack;
        logic [BYTE_W-1:0]   rdat;
        logic [BYTE_W-1:0]   ctrl_zero;
        logic [BYTE_W-1:0]   uart_ctrl_one;
        logic [BYTE_W-1:0]   baud_hi;
        logic [BYTE_W-1:0]   baud_lo;
        tx_phase_t           phase;
        logic [FRAME_W-1:0]  shreg;
        logic [BITCNT_W-1:0] bits_left;
        logic [BAUD_W-1:0]   baud_cnt;
        logic                txd;
        logic                de_active;
        logic                de_pin;
    } tx_state_t;

    localparam tx_state_t RESET_STATE = '{
        ack:           1'b0,
        rdat:          8'h00,
        ctrl_zero:     RST_CTRL_ZERO,
        uart_ctrl_one: RST_CTRL_ONE,
        baud_hi:       RST_BAUD_HI,
        baud_lo:       RST_BAUD_LO,
        phase:         PH_IDLE,
        shreg:         11'h7FF,
        bits_left:     4'h0,
        baud_cnt:      16'h0000,
        txd:           1'b1,
        de_active:     1'b0,
        de_pin:        1'b0
    };

    tx_state_t            r;
    tx_state_t            r_nxt;

    // ------------------------------------------------------------------
    // wires
    // ------------------------------------------------------------------
    logic [IDX_W-1:0]     idx;
    logic                 req;
    logic                 wr_now;
    logic [BYTE_W-1:0]    rd_mux;
    logic                 cts_n_sync;
    logic                 push_valid;
    logic                 push_ready;
    logic [ENTRY_W-1:0]   push_data;
    logic                 pop_valid;
    logic                 pop_ready;
    logic [ENTRY_W-1:0]   pop_data;
    logic                 nine_bit_mode_on;
    logic                 addr_marker_bit;
    logic                 driver_enable_polarity;
    logic                 transmit_on_bit;
    logic                 flow_gate_enable;
    logic                 parity_on;
    logic                 parity_odd;
    logic                 cts_ok;
    logic                 ninth_bit;
    logic [BAUD_W-1:0]    divisor;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    assign nine_bit_mode_on       = r.uart_ctrl_one[POS_NINE_BIT_MODE];
    assign addr_marker_bit        = r.uart_ctrl_one[POS_ADDR_MARKER];
    assign driver_enable_polarity = r.uart_ctrl_one[POS_DRV_POLARITY];
    assign transmit_on_bit        = r.ctrl_zero[POS_TRANSMIT_ON];
    assign flow_gate_enable       = r.ctrl_zero[POS_FLOW_GATE];
    assign parity_on              = r.ctrl_zero[POS_PARITY_ON];
    assign parity_odd             = r.ctrl_zero[POS_PARITY_ODD];
    assign divisor                = {r.baud_hi, r.baud_lo};

    // ------------------------------------------------------------------
    // clear-to-send pin, synchronised before use
    // ------------------------------------------------------------------
    bit_sync #(
        .RESET_VAL (CTS_N_IDLE)
    ) u_cts_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cts_n_i),
        .sync_o  (cts_n_sync)
    );

    // the pin gates only when the flow gate is enabled
    assign cts_ok = ~flow_gate_enable | ~cts_n_sync;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign idx    = wb_adr_i[ADR_W-1:2];
    assign req    = wb_cyc_i & wb_stb_i;
    // writes land on the edge where ack is sampled
    assign wr_now = req & r.ack & wb_we_i & wb_sel_i[0];

    // read multiplexer, unmapped words read as zero
    always_comb begin
        rd_mux = 8'h00;
        unique case (idx)
            IDX_STATUS0: begin
                rd_mux[POS_HOLD_EMPTY] = push_ready;
                rd_mux[POS_SHIFT_IDLE] = (r.phase == PH_IDLE) & ~pop_valid;
                rd_mux[POS_CTS_LEVEL]  = ~cts_n_sync;
            end
            IDX_CTRL_ZERO: begin
                rd_mux = r.ctrl_zero;
            end
            IDX_CTRL_ONE: begin
                rd_mux = r.uart_ctrl_one;
            end
            IDX_BAUD_HI: begin
                rd_mux = r.baud_hi;
            end
            IDX_BAUD_LO: begin
                rd_mux = r.baud_lo;
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // holding buffer between bus and shifter
    // ------------------------------------------------------------------
    // the marker is captured with the byte, so later changes hit the next byte
    assign push_valid = wr_now & (idx == IDX_TX_DATA);
    assign push_data  = {addr_marker_bit, wb_dat_i[BYTE_W-1:0]};

    small_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (BUF_DEPTH)
    ) u_hold (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_data),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_data)
    );

    // shifter takes a byte only when idle, enabled and cleared to send
    assign pop_ready = (r.phase == PH_IDLE) & transmit_on_bit & cts_ok;

    // ninth bit: marker in nine-bit mode, else parity
    always_comb begin
        ninth_bit = 1'b1;
        if (nine_bit_mode_on) begin
            ninth_bit = pop_data[BYTE_W];
        end else if (parity_on) begin
            ninth_bit = (^pop_data[BYTE_W-1:0]) ^ parity_odd;
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        r_nxt = r;

        // one-cycle ack per request
        r_nxt.ack = req & ~r.ack;
        if (req & ~r.ack) begin
            r_nxt.rdat = rd_mux;
        end

        // register writes
        if (wr_now) begin
            unique case (idx)
                IDX_CTRL_ZERO: begin
                    r_nxt.ctrl_zero = wb_dat_i[BYTE_W-1:0];
                end
                IDX_CTRL_ONE: begin
                    r_nxt.uart_ctrl_one = wb_dat_i[BYTE_W-1:0];
                end
                IDX_BAUD_HI: begin
                    r_nxt.baud_hi = wb_dat_i[BYTE_W-1:0];
                end
                IDX_BAUD_LO: begin
                    r_nxt.baud_lo = wb_dat_i[BYTE_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // frame shifter, one bit per divisor+1 clocks
        unique case (r.phase)
            PH_IDLE: begin
                r_nxt.txd       = 1'b1;
                r_nxt.de_active = 1'b0;
                if (pop_valid & pop_ready) begin
                    r_nxt.phase     = PH_SEND;
                    r_nxt.txd       = 1'b0;
                    r_nxt.de_active = 1'b1;
                    r_nxt.baud_cnt  = divisor;
                    // remaining bits after start: data, ninth, stop
                    r_nxt.shreg = {1'b1, 1'b1, ninth_bit, pop_data[BYTE_W-1:0]};
                    if (nine_bit_mode_on | parity_on) begin
                        r_nxt.bits_left = BITS_AFTER_START_9;
                    end else begin
                        r_nxt.shreg[BYTE_W] = 1'b1;
                        r_nxt.bits_left     = BITS_AFTER_START_8;
                    end
                end
            end
            PH_SEND: begin
                if (r.baud_cnt != '0) begin
                    r_nxt.baud_cnt = r.baud_cnt - 1'b1;
                end else begin
                    r_nxt.baud_cnt = divisor;
                    if (r.bits_left == '0) begin
                        r_nxt.phase     = PH_IDLE;
                        r_nxt.txd       = 1'b1;
                        r_nxt.de_active = 1'b0;
                    end else begin
                        r_nxt.txd       = r.shreg[0];
                        r_nxt.shreg     = {1'b1, r.shreg[FRAME_W-1:1]};
                        r_nxt.bits_left = r.bits_left - 1'b1;
                    end
                end
            end
        endcase

        // driver enable pin with selectable polarity
        r_nxt.de_pin = r_nxt.de_active ^ r_nxt.uart_ctrl_one[POS_DRV_POLARITY];
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= RESET_STATE;
        end else begin
            r <= r_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign wb_dat_o           = {24'h000000, r.rdat};
    assign wb_ack_o           = r.ack;
    assign txd_o              = r.txd;
    assign line_driver_on_o   = r.de_pin;
    assign tx_holding_empty_o = push_ready;

endmodule : uart_transmit_multiproc

//--- verilog/uart_tx_pkg.sv
// shared constants and types of the serial transmitter
package uart_tx_pkg;

    // ------------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------------
    localparam int unsigned ADR_W  = 32;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned IDX_W  = 30;     // word index = byte address / 4
    localparam int unsigned BYTE_W = 8;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_TX_DATA   = 30'h0000_0F40;
    localparam logic [IDX_W-1:0] IDX_STATUS0   = 30'h0000_0F41;
    localparam logic [IDX_W-1:0] IDX_CTRL_ZERO = 30'h0000_0F42;
    localparam logic [IDX_W-1:0] IDX_CTRL_ONE  = 30'h0000_0F43;
    localparam logic [IDX_W-1:0] IDX_BAUD_HI   = 30'h0000_0F46;
    localparam logic [IDX_W-1:0] IDX_BAUD_LO   = 30'h0000_0F47;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [BYTE_W-1:0] RST_CTRL_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] RST_CTRL_ONE  = 8'h00;
    localparam logic [BYTE_W-1:0] RST_BAUD_HI   = 8'h00;
    localparam logic [BYTE_W-1:0] RST_BAUD_LO   = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    // control register one
    localparam int unsigned POS_NINE_BIT_MODE = 6;
    localparam int unsigned POS_ADDR_MARKER   = 4;
    localparam int unsigned POS_DRV_POLARITY  = 3;
    // control register zero
    localparam int unsigned POS_TRANSMIT_ON   = 7;
    localparam int unsigned POS_PARITY_ON     = 4;
    localparam int unsigned POS_PARITY_ODD    = 3;
    localparam int unsigned POS_FLOW_GATE     = 1;
    // status register zero
    localparam int unsigned POS_CTS_LEVEL     = 5;
    localparam int unsigned POS_HOLD_EMPTY    = 2;
    localparam int unsigned POS_SHIFT_IDLE    = 1;

    // ------------------------------------------------------------------
    // frame layout and buffer shape
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_W    = 11;   // start, 8 data, ninth, stop
    localparam int unsigned BITCNT_W   = 4;
    localparam logic [BITCNT_W-1:0] BITS_AFTER_START_9 = 4'hA;
    localparam logic [BITCNT_W-1:0] BITS_AFTER_START_8 = 4'h9;
    localparam int unsigned BAUD_W     = 16;
    localparam int unsigned ENTRY_W    = 9;    // marker bit and data byte
    localparam int unsigned BUF_DEPTH  = 2;
    localparam logic        CTS_N_IDLE = 1'b1;

    // ------------------------------------------------------------------
    // transmitter phases
    // ------------------------------------------------------------------
    typedef enum logic {
        PH_IDLE,
        PH_SEND
    } tx_phase_t;

endpackage : uart_tx_pkg

//--- verilog/bit_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps

module bit_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      sync_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;

    sync_state_t r;
    sync_state_t r_nxt;

    // first stage feeds only the second stage
    always_comb begin
        r_nxt        = r;
        r_nxt.first  = async_i;
        r_nxt.second = r.first;
    end

    // register the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{first: RESET_VAL, second: RESET_VAL};
        end else begin
            r <= r_nxt;
        end
    end

    assign sync_o = r.second;

endmodule : bit_sync

//--- verilog/small_fifo.sv
// small valid/ready buffer, depth and width set by parameters
`timescale 1ns/1ps

module small_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST  = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULLC = (AW + 1)'(DEPTH);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
    } fifo_state_t;

    fifo_state_t r;
    fifo_state_t r_nxt;
    logic        push;
    logic        pop;

    // honest full and empty
    assign in_ready_o  = (r.count != FULLC);
    assign out_valid_o = (r.count != '0);
    assign out_data_o  = r.mem[r.rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointer and count update
    always_comb begin
        r_nxt = r;
        if (push) begin
            r_nxt.mem[r.wr_ptr] = in_data_i;
            r_nxt.wr_ptr        = (r.wr_ptr == LAST) ? '0 : r.wr_ptr + 1'b1;
        end
        if (pop) begin
            r_nxt.rd_ptr = (r.rd_ptr == LAST) ? '0 : r.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            r_nxt.count = r.count + 1'b1;
        end else if (pop && !push) begin
            r_nxt.count = r.count - 1'b1;
        end
    end

    // register the state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

endmodule : small_fifo

//--- verif/uart_transmit_multiproc_asserts.sv
// port-level property checks of the serial transmitter
`timescale 1ns/1ps

module uart_transmit_multiproc_asserts
    import uart_tx_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADR_W-1:0]  wb_adr_i,
    input wire logic [SEL_W-1:0]  wb_sel_i,
    input wire logic [DAT_W-1:0]  wb_dat_i,
    input wire logic [DAT_W-1:0]  wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              cts_n_i,
    input wire logic              txd_o,
    input wire logic              line_driver_on_o,
    input wire logic              tx_holding_empty_o
);
    logic [7:0] ctrl0_r, ctrl1_r;
    logic       wr_ok, data_wr, idle, run;

    // --------------------------------------------------------------
    // control register shadow
    // --------------------------------------------------------------
    assign wr_ok   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign data_wr = wr_ok && (wb_adr_i[31:2] == IDX_TX_DATA);
    assign idle    = txd_o && (line_driver_on_o == ctrl1_r[POS_DRV_POLARITY]);
    assign run     = ctrl0_r[POS_TRANSMIT_ON] && !ctrl0_r[POS_FLOW_GATE];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0_r <= 8'h00;
            ctrl1_r <= 8'h00;
        end else if (wr_ok && wb_adr_i[31:2] == IDX_CTRL_ZERO) begin
            ctrl0_r <= wb_dat_i[7:0];
        end else if (wr_ok && wb_adr_i[31:2] == IDX_CTRL_ONE) begin
            ctrl1_r <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // rules seen at the ports
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("late ack");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_reset_idle: assert property (disable iff (1'b0) rst_i |=>
        txd_o && !line_driver_on_o && tx_holding_empty_o)
        else $error("not idle after reset");
    chk_de_frame: assert property (!txd_o |->
        line_driver_on_o == !ctrl1_r[POS_DRV_POLARITY])
        else $error("driver off in frame");
    chk_off_no_start: assert property (!ctrl0_r[POS_TRANSMIT_ON] && idle |=> txd_o)
        else $error("sent while off");
    chk_cts_gate: assert property (cts_n_i [*3] ##1 (cts_n_i && ctrl0_r[POS_FLOW_GATE]
        && idle) |=> txd_o)
        else $error("sent without cts");
    chk_empty_fall: assert property ($fell(tx_holding_empty_o) |-> $past(data_wr))
        else $error("empty fell, no write");
    chk_pop_starts: assert property ($rose(tx_holding_empty_o) |-> $fell(txd_o))
        else $error("pop without start");
    chk_drain_bound: assert property (!tx_holding_empty_o && run
        |-> ##[1:200] (tx_holding_empty_o || !run))
        else $error("no drain");
endmodule : uart_transmit_multiproc_asserts

bind uart_transmit_multiproc uart_transmit_multiproc_asserts uart_transmit_multiproc_asserts_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cts_n_i(cts_n_i), .txd_o(txd_o),
    .line_driver_on_o(line_driver_on_o), .tx_holding_empty_o(tx_holding_empty_o));

//--- verif/serial_rx_model.sv
// remote receiver model: decodes serial frames and drives clear-to-send
`timescale 1ns/1ps

module serial_rx_model (
    input  wire logic        clk_i,
    input  wire logic        txd_i,
    input  wire logic [15:0] div_i,
    input  wire logic        nine_i,
    input  wire logic        hold_i,
    output logic             cts_n_o,
    output logic      [8:0]  word_o,
    output logic             stb_o
);
    int         p;
    logic       n, ok;
    logic [8:0] w;

    // cts low while ready for data
    assign cts_n_o = hold_i;

    // falling-edge frame decoder; bad framing gives X
    initial begin
        stb_o  = 1'b0;
        word_o = 9'h000;
        forever begin
            @(negedge clk_i);
            if (txd_i === 1'b0) begin
                p = int'(div_i) + 1;
                n = nine_i;
                w = 9'h000;
                repeat ((p - 1) / 2) @(negedge clk_i);
                ok = (txd_i === 1'b0);
                for (int i = 0; i < (n ? 9 : 8); i++) begin
                    repeat (p) @(negedge clk_i);
                    w[i] = txd_i;
                end
                repeat (p) @(negedge clk_i);
                ok = ok && (txd_i === 1'b1);
                word_o <= ok ? w : 9'hXXX;
                stb_o  <= 1'b1;
                @(negedge clk_i);
                stb_o  <= 1'b0;
            end
        end
    end
endmodule : serial_rx_model

//--- verif/test_uart_transmit_multiproc.sv
// self-checking bench of the serial transmitter
`timescale 1ns/1ps

module test_uart_transmit_multiproc;
    import uart_tx_pkg::*;

    logic        clk_i  = 1'b0;
    logic        rst_i  = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we  = 1'b0;
    logic [31:0] wb_adr = 32'h0;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        txd;
    logic        de;
    logic        empty_o;
    logic        cts_n;
    logic        hold   = 1'b1;
    logic        nine   = 1'b0;
    logic [15:0] div    = 16'h0000;
    logic [8:0]  rx_word;
    logic        rx_stb;
    int          n_errors = 0;
    int          n_checks = 0;
    int          n_rx     = 0;
    int          cyc_cnt  = 0;
    int          seed     = 32'hD73DA0ED;
    logic [31:0] expq[$];
    logic [31:0] rdq[$];
    logic [7:0]  t0[5] = '{8'h80, 8'h80, 8'h80, 8'h90, 8'h98};
    logic [7:0]  t1[5] = '{8'h10, 8'h50, 8'h48, 8'h00, 8'h00};

    always #2.5 clk_i = ~clk_i;

    uart_transmit_multiproc uart_transmit_multiproc_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cts_n_i(cts_n), .txd_o(txd), .line_driver_on_o(de),
        .tx_holding_empty_o(empty_o));
    serial_rx_model serial_rx_model_inst (
        .clk_i(clk_i), .txd_i(txd), .div_i(div), .nine_i(nine), .hold_i(hold),
        .cts_n_o(cts_n), .word_o(rx_word), .stb_o(rx_stb));

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // one classic cycle; a read notes its expected byte
    task automatic wb(input logic w, input logic [29:0] idx, input logic [7:0] d,
                      input logic [7:0] e = 8'h00);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h0, d};
        wb_sel <= 4'hF;
        if (!w) rdq.push_back({24'h0, e});
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // expected frame word
    function automatic logic [31:0] expw(input logic [7:0] c0, c1, d);
        if (c1[POS_NINE_BIT_MODE]) return {23'h0, c1[POS_ADDR_MARKER], d};
        if (c0[POS_PARITY_ON]) return {23'h0, c0[POS_PARITY_ODD] ^ (^d), d};
        return {24'h0, d};
    endfunction : expw

    // result watcher
    always @(negedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we === 1'b0 && rdq.size() > 0) begin
            check("read", wb_dat_o, rdq.pop_front());
        end
        if (rx_stb === 1'b1) begin
            n_rx++;
            check("frame", 32'(rx_word), expq.size() > 0 ? expq.pop_front() : 32'hFFFFFFFF);
        end
    end

    // hang guard
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_errors++;
            conclude();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] c0, c1, d;
        int         base;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        wb(1'b0, IDX_CTRL_ONE, 8'h00, 8'h00);
        wb(1'b0, IDX_STATUS0, 8'h00, 8'h06);
        wb(1'b1, IDX_CTRL_ONE, 8'hA5);
        wb(1'b0, IDX_CTRL_ONE, 8'h00, 8'hA5);
        wb(1'b0, 30'h0000_0F50, 8'h00, 8'h00);
        wb(1'b1, IDX_BAUD_HI, 8'h00);
        wb(1'b1, IDX_BAUD_LO, 8'h01);
        div = 16'h0001;
        $display("register test done");
        // all frame formats, marker flipped per byte
        for (int k = 0; k < 5; k++) begin
            c0 = t0[k];
            c1 = t1[k];
            wb(1'b1, IDX_CTRL_ONE, c1);
            wb(1'b1, IDX_CTRL_ZERO, c0);
            nine = c1[POS_NINE_BIT_MODE] | c0[POS_PARITY_ON];
            base = n_rx;
            for (int j = 0; j < 2; j++) begin
                d = 8'($random(seed));
                expq.push_back(expw(c0, c1, d));
                while (empty_o !== 1'b1) @(posedge clk_i);
                wb(1'b1, IDX_TX_DATA, d);
                c1[POS_ADDR_MARKER] = ~c1[POS_ADDR_MARKER];
                wb(1'b1, IDX_CTRL_ONE, c1);
            end
            while (n_rx < base + 2) @(posedge clk_i);
        end
        $display("format test done");
        // fill while off, third byte dropped, then stall on cts
        wb(1'b1, IDX_CTRL_ZERO, 8'h00);
        wb(1'b1, IDX_CTRL_ONE, 8'h00);
        nine = 1'b0;
        base = n_rx;
        for (int k = 0; k < 3; k++) begin
            d = 8'($random(seed));
            if (k < 2) expq.push_back({24'h0, d});
            wb(1'b1, IDX_TX_DATA, d);
        end
        @(negedge clk_i);
        check("empty", 32'(empty_o), 32'h0);
        @(posedge clk_i);
        wb(1'b0, IDX_STATUS0, 8'h00, 8'h00);
        repeat (100) @(posedge clk_i);
        check("frames", n_rx, base);
        wb(1'b1, IDX_CTRL_ZERO, 8'h82);
        repeat (100) @(posedge clk_i);
        check("frames", n_rx, base);
        hold <= 1'b0;
        while (n_rx < base + 2) @(posedge clk_i);
        @(negedge clk_i);
        check("empty", 32'(empty_o), 32'h1);
        repeat (100) @(posedge clk_i);
        check("frames", n_rx, base + 2);
        $display("buffer test done");
        conclude();
    end
endmodule : test_uart_transmit_multiproc
